// >>> logic/dce_pkg.sv
// Register map, field layout and constants of the DMA checksum engine
package dce_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_LAST_ACCESS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h20;
    localparam logic [7:0] ADDR_TAPS = 8'h30;
    // Control field positions
    localparam int BYTE_ORDER_LSB = 28;
    localparam int WRITE_REORDER_BIT = 27;
    localparam int BIT_ORDER_BIT = 24;
    localparam int POLY_LEN_LSB = 8;
    localparam int ENABLE_BIT = 7;
    localparam int APPEND_BIT = 6;
    localparam int TYPE_BIT = 5;
    localparam int CHANNEL_LSB = 0;
    // Writable control bits; the rest read as zero
    localparam logic [31:0] CONTROL_MASK = 32'h3900_1FE7;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] TAPS_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    // Byte order codes
    localparam logic [1:0] ORDER_NONE = 2'h0;
    localparam logic [1:0] ORDER_WORD_REV = 2'h1;
    localparam logic [1:0] ORDER_HALF_SWAP = 2'h2;
    localparam logic [1:0] ORDER_HALF_REV = 2'h3;
endpackage

// >>> logic/dce_engine.sv
// DMA datapath checksum and CRC engine with its register file
// Functional notes
// - Record bus address of every DMA access
// - Byte order field selects four swap patterns
// - Write-reorder bit reorders destination data
// - Write-reorder set blocks append mode
// - Bit order reflects checksum input
// - Bit order reflects CRC shift input
// - Length field is polynomial length minus one
// - Enable routes selected channel through engine
// - Append mode absorbs data, writes result
// - Pass mode writes data to destination
// - Type bit picks checksum or CRC
// - Channel field selects channels zero to seven
// - Result register 32 bits, resets zero
// - Unimplemented control bits read zero
// - Result write seeds, read returns running value
// - CRC result bits above length read zero
// - Checksum is 16-bit ones' complement
// - Tap bits enable feedback per stage
module dce_engine #(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    // DMA access monitor
    input wire logic access_valid_i,
    input wire logic [31:0] access_addr_i,
    // Channel data element from the source
    input wire logic elem_valid_i,
    input wire logic [2:0] elem_channel_i,
    input wire logic [31:0] elem_data_i,
    input wire logic block_done_i,
    // Toward the destination
    output logic dest_write_o,
    output logic [31:0] dest_data_o,
    output logic append_write_o,
    output logic [31:0] append_data_o
);
    logic [31:0] last_addr_q;
    logic [31:0] control_q;
    logic [31:0] result_q;
    logic [31:0] result_d;
    logic [31:0] taps_q;
    logic [31:0] read_value;
    logic [31:0] ordered;
    logic [31:0] view;
    logic [31:0] ctl_wr;
    logic [1:0] byte_order;
    logic write_reorder;
    logic bit_order;
    logic [4:0] poly_len;
    logic enabled;
    logic append;
    logic is_checksum;
    logic [2:0] channel;
    logic hit;

    assign byte_order = control_q[dce_pkg::BYTE_ORDER_LSB +: 2];
    assign write_reorder = control_q[dce_pkg::WRITE_REORDER_BIT];
    assign bit_order = control_q[dce_pkg::BIT_ORDER_BIT];
    assign poly_len = control_q[dce_pkg::POLY_LEN_LSB +: 5];
    assign enabled = control_q[dce_pkg::ENABLE_BIT];
    assign append = control_q[dce_pkg::APPEND_BIT];
    assign is_checksum = control_q[dce_pkg::TYPE_BIT];
    assign channel = control_q[dce_pkg::CHANNEL_LSB +: 3];
    // Channel code maps straight to channel number
    assign hit = elem_valid_i && enabled && (elem_channel_i == channel);

    // Last DMA access address
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            last_addr_q <= dce_pkg::ADDR_RESET;
        end else if (access_valid_i) begin
            last_addr_q <= access_addr_i;
        end
    end

    // Control: append refused while write-reorder is set, by the written value
    always_comb begin
        ctl_wr = reg_wdata_i & dce_pkg::CONTROL_MASK;
        if (ctl_wr[dce_pkg::WRITE_REORDER_BIT]) begin
            ctl_wr[dce_pkg::APPEND_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            control_q <= dce_pkg::CONTROL_RESET;
        end else if (reg_write_i && reg_addr_i == dce_pkg::ADDR_CONTROL) begin
            control_q <= ctl_wr;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            taps_q <= dce_pkg::TAPS_RESET;
        end else if (reg_write_i && reg_addr_i == dce_pkg::ADDR_TAPS) begin
            taps_q <= reg_wdata_i;
        end
    end

    // Byte reordering of the source word
    always_comb begin
        case (byte_order)
            dce_pkg::ORDER_WORD_REV: ordered = {elem_data_i[7:0], elem_data_i[15:8],
                                                elem_data_i[23:16], elem_data_i[31:24]};
            dce_pkg::ORDER_HALF_SWAP: ordered = {elem_data_i[15:0], elem_data_i[31:16]};
            dce_pkg::ORDER_HALF_REV: ordered = {elem_data_i[23:16], elem_data_i[31:24],
                                                elem_data_i[7:0], elem_data_i[15:8]};
            default: ordered = elem_data_i;
        endcase
    end

    function automatic logic [31:0] reflect32(input logic [31:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31 - i];
        end
        return r;
    endfunction

    function automatic logic [15:0] reflect16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // Running result, whole word per element; the shift loop is unrolled
    // by synthesis, trading area for a one-cycle update
    always_comb begin
        logic [31:0] crc;
        logic [31:0] word;
        logic [16:0] s;
        logic fb;
        logic [15:0] h0;
        logic [15:0] h1;
        crc = result_q;
        word = bit_order ? reflect32(ordered) : ordered;
        s = '0;
        fb = 1'b0;
        h0 = '0;
        h1 = '0;
        result_d = result_q;
        if (is_checksum) begin
            h0 = bit_order ? reflect16(ordered[31:16]) : ordered[31:16];
            h1 = bit_order ? reflect16(ordered[15:0]) : ordered[15:0];
            s = {1'b0, result_q[15:0]} + {1'b0, h0};
            s = {1'b0, s[15:0]} + {16'h0000, s[16]};
            s = {1'b0, s[15:0]} + {1'b0, h1};
            s = {1'b0, s[15:0]} + {16'h0000, s[16]};
            result_d = {16'h0000, s[15:0]};
        end else begin
            for (int b = 31; b >= 0; b--) begin
                fb = word[b] ^ crc[poly_len];
                for (int k = 31; k > 0; k--) begin
                    crc[k] = taps_q[k] ? (crc[k - 1] ^ fb) : crc[k - 1];
                end
                crc[0] = fb;
            end
            for (int k = 0; k < 32; k++) begin
                if (k > poly_len) begin
                    crc[k] = 1'b0;
                end
            end
            result_d = crc;
        end
    end

    // Result register: software seed wins over an element in the same cycle
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            result_q <= dce_pkg::RESULT_RESET;
        end else if (reg_write_i && reg_addr_i == dce_pkg::ADDR_RESULT) begin
            result_q <= is_checksum ? {16'h0000, ~reg_wdata_i[15:0]} : reg_wdata_i;
        end else if (hit) begin
            result_q <= result_d;
        end
    end

    // Register-visible result view
    always_comb begin
        view = '0;
        if (is_checksum) begin
            view = {16'h0000, ~result_q[15:0]};
        end else begin
            for (int k = 0; k < 32; k++) begin
                view[k] = (k <= poly_len) ? result_q[k] : 1'b0;
            end
        end
    end

    always_comb begin
        read_value = 32'h0000_0000;
        if (reg_addr_i == dce_pkg::ADDR_LAST_ACCESS) begin
            read_value = last_addr_q;
        end else if (reg_addr_i == dce_pkg::ADDR_CONTROL) begin
            read_value = control_q;
        end else if (reg_addr_i == dce_pkg::ADDR_RESULT) begin
            read_value = view;
        end else if (reg_addr_i == dce_pkg::ADDR_TAPS) begin
            read_value = taps_q;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_read_i) begin
            reg_rdata_o <= read_value;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // Destination path, one cycle behind the source element
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            dest_write_o <= 1'b0;
            dest_data_o <= 32'h0000_0000;
        end else begin
            dest_write_o <= elem_valid_i && !(hit && append);
            if (elem_valid_i) begin
                dest_data_o <= (hit && write_reorder) ? ordered : elem_data_i;
            end
        end
    end

    // Append write of the result at block end of the selected channel
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            append_write_o <= 1'b0;
            append_data_o <= 32'h0000_0000;
        end else begin
            append_write_o <= block_done_i && enabled && append && (elem_channel_i == channel);
            if (block_done_i) begin
                append_data_o <= view;
            end
        end
    end

    a_address_capture: assert property (@(posedge clock_i) disable iff (reset_i)
        access_valid_i |=> last_addr_q == $past(access_addr_i))
        else $error("last access address not captured");
    a_append_refused: assert property (@(posedge clock_i) disable iff (reset_i)
        !(control_q[dce_pkg::WRITE_REORDER_BIT] && control_q[dce_pkg::APPEND_BIT]))
        else $error("append set while write reorder set");
    a_unused_zero: assert property (@(posedge clock_i) disable iff (reset_i)
        (control_q & ~dce_pkg::CONTROL_MASK) == 32'h0000_0000)
        else $error("unimplemented control bit set");
    a_append_absorbs: assert property (@(posedge clock_i) disable iff (reset_i)
        (hit && append) |=> !dest_write_o)
        else $error("append mode wrote data to destination");
    a_pass_writes: assert property (@(posedge clock_i) disable iff (reset_i)
        (elem_valid_i && !append) |=> dest_write_o)
        else $error("pass mode dropped a data element");
    a_disabled_unchanged: assert property (@(posedge clock_i) disable iff (reset_i)
        (elem_valid_i && !enabled) |=> dest_write_o && dest_data_o == $past(elem_data_i))
        else $error("disabled engine altered data");
    a_checksum_upper: assert property (@(posedge clock_i) disable iff (reset_i)
        (reg_read_i && reg_addr_i == dce_pkg::ADDR_RESULT && is_checksum) |=> reg_rdata_o[31:16] == 16'h0000)
        else $error("checksum upper half not zero");
    a_seed_load: assert property (@(posedge clock_i) disable iff (reset_i)
        (reg_write_i && reg_addr_i == dce_pkg::ADDR_RESULT && !is_checksum) |=> result_q == $past(reg_wdata_i))
        else $error("seed not loaded");
    a_idle_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        (!hit && !reg_write_i) |=> $stable(result_q))
        else $error("result changed without an element");
    a_rdata_idle: assert property (@(posedge clock_i) disable iff (reset_i)
        !reg_read_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data present without a read");
    a_reorder_off: assert property (@(posedge clock_i) disable iff (reset_i)
        (elem_valid_i && !write_reorder) |=> dest_data_o == $past(elem_data_i))
        else $error("destination data altered with reorder off");
    a_other_unchanged: assert property (@(posedge clock_i) disable iff (reset_i)
        (elem_valid_i && !hit) |=> dest_data_o == $past(elem_data_i))
        else $error("unselected channel data altered");
    // Control never changes in a read's cycle, so the past length is the one read
    a_crc_upper: assert property (@(posedge clock_i) disable iff (reset_i)
        (reg_read_i && reg_addr_i == dce_pkg::ADDR_RESULT && !is_checksum)
        |=> (reg_rdata_o >> ({1'b0, $past(poly_len)} + 6'h01)) == 32'h0000_0000)
        else $error("result bits above length not zero");
    a_other_done: assert property (@(posedge clock_i) disable iff (reset_i)
        (block_done_i && elem_channel_i != channel) |=> !append_write_o)
        else $error("append written for another channel");
    a_disabled_no_append: assert property (@(posedge clock_i) disable iff (reset_i)
        (block_done_i && !enabled) |=> !append_write_o)
        else $error("append written while engine off");
    c_pass_reorder: cover property (@(posedge clock_i) hit && write_reorder && !append);
    c_append_done: cover property (@(posedge clock_i) append_write_o);
    c_checksum_step: cover property (@(posedge clock_i) hit && is_checksum);
    c_crc_step: cover property (@(posedge clock_i) hit && !is_checksum && bit_order);
    c_seed_write: cover property (@(posedge clock_i) reg_write_i && reg_addr_i == dce_pkg::ADDR_RESULT);
endmodule

// >>> verif/dce_dma_model.sv
// Behavioural DMA channel datapath feeding the checksum engine
module dce_dma_model (
    // Clock
    input wire logic clock_i,
    // Toward the engine
    output logic access_valid_o,
    output logic [31:0] access_addr_o,
    output logic elem_valid_o,
    output logic [2:0] elem_channel_o,
    output logic [31:0] elem_data_o,
    output logic block_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        access_valid_o = 1'b0;
        access_addr_o = 32'h0000_0000;
        elem_valid_o = 1'b0;
        elem_channel_o = 3'h0;
        elem_data_o = 32'h0000_0000;
        block_done_o = 1'b0;
    end
    // Whole aligned words only; idle cycles model a slow channel
    task automatic move(input logic [2:0] ch, input logic [31:0] d, input logic [31:0] a, input int gap);
        repeat (gap) @(posedge clock_i);
        @(posedge clock_i);
        access_valid_o <= 1'b1;
        access_addr_o <= {a[31:2], 2'b00};
        elem_valid_o <= 1'b1;
        elem_channel_o <= ch;
        elem_data_o <= d;
        @(posedge clock_i);
        access_valid_o <= 1'b0;
        elem_valid_o <= 1'b0;
        // Released lines show garbage, not the old word
        access_addr_o <= ~a;
        elem_data_o <= ~d;
        elem_channel_o <= ~ch;
    endtask
    task automatic finish(input logic [2:0] ch);
        @(posedge clock_i);
        block_done_o <= 1'b1;
        elem_channel_o <= ch;
        @(posedge clock_i);
        block_done_o <= 1'b0;
        elem_channel_o <= ~ch;
    endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the DMA checksum engine
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] D = 32'h1122_3344;
    logic clock_i, reset_i, reg_write_i, reg_read_i, av, ev, bd, dest_write_o, append_write_o;
    logic [7:0] reg_addr_i;
    logic [2:0] ech;
    logic [31:0] reg_wdata_i, reg_rdata_o, aa, ed, dest_data_o, append_data_o, last_dest, last_app, got;
    int n_errors = 0;
    int tests_run = 0;
    int n_dest = 0;
    int n_app = 0;
    int n0;
    dce_engine dce_engine_i (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .access_valid_i(av), .access_addr_i(aa), .elem_valid_i(ev),
        .elem_channel_i(ech), .elem_data_i(ed), .block_done_i(bd), .dest_write_o(dest_write_o),
        .dest_data_o(dest_data_o), .append_write_o(append_write_o), .append_data_o(append_data_o));
    dce_dma_model dce_dma_model_i (.clock_i(clock_i), .access_valid_o(av), .access_addr_o(aa),
        .elem_valid_o(ev), .elem_channel_o(ech), .elem_data_o(ed), .block_done_o(bd));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // Mid-cycle sampling keeps the monitor clear of the launching edge
    always @(negedge clock_i) begin
        if (dest_write_o === 1'b1) begin
            n_dest <= n_dest + 1;
            last_dest <= dest_data_o;
        end
        if (append_write_o === 1'b1) begin
            n_app <= n_app + 1;
            last_app <= append_data_o;
        end
    end
    function automatic logic [31:0] ctl(input logic [1:0] o, input logic w, b, input logic [4:0] p,
        input logic e, ap, t, input logic [2:0] c);
        ctl = {2'b00, o, w, 2'b00, b, 11'h000, p, e, ap, t, 2'b00, c};
    endfunction
    function automatic logic [31:0] reord(input logic [31:0] d, input logic [1:0] o);
        case (o)
            2'h1: reord = {d[7:0], d[15:8], d[23:16], d[31:24]};
            2'h2: reord = {d[15:0], d[31:16]};
            2'h3: reord = {d[23:16], d[31:24], d[7:0], d[15:8]};
            default: reord = d;
        endcase
    endfunction
    // Bit-serial reference, bit 31 first, masked to the polynomial length
    function automatic logic [31:0] crc(input logic [31:0] d, input logic rf);
        logic [31:0] r;
        logic [31:0] w;
        logic fb;
        r = 32'h0000_0000;
        for (int i = 0; i < 32; i++) w[i] = rf ? d[31 - i] : d[i];
        for (int i = 31; i >= 0; i--) begin
            fb = r[7] ^ w[i];
            r = (r << 1) ^ (fb ? 32'h0000_0007 : 32'h0000_0000);
            r[0] = fb;
        end
        crc = r & 32'h0000_00FF;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask
    task automatic send(input logic [2:0] ch, input logic [31:0] d, input logic [31:0] a, input int gap);
        dce_dma_model_i.move(ch, d, a, gap);
        @(posedge clock_i);
        #1;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(40 * 4000);
        n_errors++;
        give_verdict();
    end
    initial begin
        reset_i = 1'b1;
        reg_write_i = 1'b0;
        reg_read_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0000_0000;
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        wr(8'h40, 32'hFFFF_FFFF);
        for (int i = 0; i < 5; i++) rchk(8'(i * 16), 32'h0000_0000);
        wr(dce_pkg::ADDR_CONTROL, 32'hFFFF_FFFF);
        rchk(dce_pkg::ADDR_CONTROL, 32'h3900_1FA7);
        wr(dce_pkg::ADDR_CONTROL, 32'h0000_00FF);
        rchk(dce_pkg::ADDR_CONTROL, 32'h0000_00E7);
        for (int o = 0; o < 4; o++) begin
            wr(dce_pkg::ADDR_CONTROL, ctl(2'(o), 1'b1, 1'b0, 5'h1F, 1'b1, 1'b0, 1'b0, 3'h3));
            send(3'h3, D, 32'h1000_0000 + 32'(o * 4), o);
            chk(last_dest, reord(D, 2'(o)));
            rchk(dce_pkg::ADDR_LAST_ACCESS, 32'h1000_0000 + 32'(o * 4));
        end
        wr(dce_pkg::ADDR_CONTROL, ctl(2'h1, 1'b0, 1'b0, 5'h1F, 1'b1, 1'b0, 1'b0, 3'h3));
        send(3'h3, D, 32'h1000_0020, 0);
        chk(last_dest, D);
        // Engine off: data untouched and result frozen
        wr(dce_pkg::ADDR_CONTROL, ctl(2'h1, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b0, 1'b0, 3'h3));
        wr(dce_pkg::ADDR_RESULT, 32'hCAFE_F00D);
        send(3'h3, D, 32'h1000_0024, 0);
        chk(last_dest, D);
        rchk(dce_pkg::ADDR_RESULT, 32'hCAFE_F00D);
        wr(dce_pkg::ADDR_CONTROL, ctl(2'h0, 1'b0, 1'b0, 5'h03, 1'b1, 1'b0, 1'b1, 3'h3));
        wr(dce_pkg::ADDR_RESULT, 32'h1234_5678);
        rchk(dce_pkg::ADDR_RESULT, 32'h0000_5678);
        wr(dce_pkg::ADDR_RESULT, 32'h0000_0000);
        send(3'h3, 32'h0001_0002, 32'h1000_0030, 0);
        send(3'h3, 32'h0003_0004, 32'h1000_0034, 0);
        rchk(dce_pkg::ADDR_RESULT, 32'h0000_FFF5);
        wr(dce_pkg::ADDR_CONTROL, ctl(2'h0, 1'b0, 1'b1, 5'h00, 1'b1, 1'b0, 1'b1, 3'h3));
        wr(dce_pkg::ADDR_RESULT, 32'h0000_0000);
        send(3'h3, 32'h0001_0000, 32'h1000_0038, 0);
        rchk(dce_pkg::ADDR_RESULT, 32'h0000_7FFF);
        for (int c = 0; c < 8; c++) begin
            wr(dce_pkg::ADDR_CONTROL, ctl(2'h0, 1'b0, 1'b0, 5'h00, 1'b1, 1'b0, 1'b1, 3'(c)));
            wr(dce_pkg::ADDR_RESULT, 32'h0000_0000);
            send(3'(c + 1), 32'h0000_0010, 32'h1000_0040, 0);
            send(3'(c), 32'h0000_0001, 32'h1000_0044, 0);
            rchk(dce_pkg::ADDR_RESULT, 32'h0000_FFFE);
        end
        wr(dce_pkg::ADDR_TAPS, 32'h0000_0007);
        rchk(dce_pkg::ADDR_TAPS, 32'h0000_0007);
        for (int b = 0; b < 2; b++) begin
            wr(dce_pkg::ADDR_CONTROL, ctl(2'h0, 1'b0, 1'(b), 5'h07, 1'b1, 1'b0, 1'b0, 3'h3));
            wr(dce_pkg::ADDR_RESULT, 32'h0000_0000);
            send(3'h3, D, 32'h1000_0050, 0);
            rchk(dce_pkg::ADDR_RESULT, crc(D, 1'(b)));
        end
        wr(dce_pkg::ADDR_RESULT, 32'hFFFF_FFFF);
        rchk(dce_pkg::ADDR_RESULT, 32'h0000_00FF);
        // Append: element absorbed, result written at block end
        wr(dce_pkg::ADDR_CONTROL, ctl(2'h0, 1'b0, 1'b0, 5'h07, 1'b1, 1'b1, 1'b0, 3'h5));
        wr(dce_pkg::ADDR_RESULT, 32'h0000_0000);
        chk(32'(n_dest), 32'h0000_001B);
        n0 = n_dest;
        send(3'h5, D, 32'h1000_0060, 2);
        chk(32'(n_dest), 32'(n0));
        dce_dma_model_i.finish(3'h2);
        @(posedge clock_i);
        #1;
        chk(32'(n_app), 32'h0000_0000);
        dce_dma_model_i.finish(3'h5);
        @(posedge clock_i);
        #1;
        chk(last_app, crc(D, 1'b0));
        chk(32'(n_app), 32'h0000_0001);
        give_verdict();
    end
endmodule
